/* File: logic/atm_top.sv */
// Contract
// - srst enable set means software reset is issued during drive init.
// - skip pin reset set keeps the reset pin idle except after power-up.
// - ata drives use udma only if ata udma enable and a mode matches.
// - atapi drives use udma only if atapi udma enable and a mode matches.
// - udma field bits 4,3,2 enable modes 4,3,2; nothing else exists.
// - pick the highest udma mode enabled and supported by the drive.
// - multiword dma is used when enabled and supported by the drive and no udma mode is chosen.
// - each pio field bit permits its mode; bit 1 is pio mode 4.
// - run the highest enabled supported pio mode; mode 0 always allowed.
`timescale 1ns/1ps
module atm_top
    import atm_pkg::*;
#(
    parameter int RST_CYC = PIN_RST_CYC
)(
    // clock and reset
    input  wire logic       clock,
    input  wire logic       rst_n,
    // configuration byte load and readback
    input  wire logic       cfg_wr,
    input  wire logic [7:0] cfg_addr,
    input  wire logic [7:0] cfg_wdata,
    output logic      [7:0] cfg_rdata,
    // initialization control
    input  wire logic       init_req,
    output logic            init_busy,
    // drive reset
    output logic            drive_hw_reset_pin_n,
    output logic            srst_req,
    input  wire logic       srst_done,
    // drive capability report
    output logic            ident_req,
    input  wire logic       cap_valid,
    input  wire logic       drv_is_atapi,
    input  wire logic [5:0] drv_udma_sup,
    input  wire logic       drv_mwdma_sup,
    input  wire logic [1:0] drv_pio_sup,
    // chosen transfer mode
    output logic            mode_valid,
    output atm_xfer_t       xfer_kind,
    output logic      [2:0] xfer_mode
);
    localparam int CW = $clog2(RST_CYC + 1);

    if (RST_CYC < 1) begin : g_chk
        $error("RST_CYC must be at least one cycle");
    end

    typedef struct packed {
        atm_state_t  st;
        logic [CW-1:0] cnt;
        logic        pwr_up;
        logic        pin_n;
        logic        srst;
        logic        ident;
        logic        busy;
        logic [7:0]  rst_cfg;
        logic [7:0]  udma_cfg;
        logic [7:0]  pio_cfg;
        logic [7:0]  rdata;
        logic        valid;
        atm_xfer_t   kind;
        logic [2:0]  mode;
    } atm_regs_t;

    atm_regs_t s_r;
    atm_regs_t s_nxt;
    atm_sel_if sel_if ();
    logic      start;
    logic      cap;

    assign sel_if.udma_cfg  = s_r.udma_cfg;
    assign sel_if.pio_cfg   = s_r.pio_cfg;
    assign sel_if.is_atapi  = drv_is_atapi;
    assign sel_if.drv_udma  = drv_udma_sup;
    assign sel_if.drv_mwdma = drv_mwdma_sup;
    assign sel_if.drv_pio   = drv_pio_sup;

    atm_mode_sel u_sel (
        .s (sel_if.sel)
    );

    // power-up starts the first init without waiting for a request
    assign start = (s_r.st == ST_IDLE) && (init_req || s_r.pwr_up);
    assign cap   = (s_r.st == ST_IDENT) && cap_valid;

    always_comb begin
        s_nxt = s_r;
        if (cfg_wr) begin
            case (cfg_addr)
                CFG_RST_OFS:  s_nxt.rst_cfg  = cfg_wdata;
                CFG_UDMA_OFS: s_nxt.udma_cfg = cfg_wdata;
                CFG_PIO_OFS:  s_nxt.pio_cfg  = cfg_wdata;
                default:      ;
            endcase
        end
        case (cfg_addr)
            CFG_RST_OFS:  s_nxt.rdata = s_r.rst_cfg;
            CFG_UDMA_OFS: s_nxt.rdata = s_r.udma_cfg;
            CFG_PIO_OFS:  s_nxt.rdata = s_r.pio_cfg;
            default:      s_nxt.rdata = 8'h00;
        endcase
        case (s_r.st)
            ST_IDLE: begin
                if (start) begin
                    s_nxt.busy   = 1'b1;
                    s_nxt.valid  = 1'b0;
                    s_nxt.pwr_up = 1'b0;
                    // chip power-up always pulses the pin
                    if (s_r.pwr_up || !s_r.rst_cfg[SKIP_PIN_BIT]) begin
                        s_nxt.st    = ST_PINRST;
                        s_nxt.pin_n = 1'b0;
                        s_nxt.cnt   = CW'(RST_CYC - 1);
                    end else if (s_r.rst_cfg[SRST_EN_BIT]) begin
                        s_nxt.st   = ST_SRST;
                        s_nxt.srst = 1'b1;
                    end else begin
                        // both resets off is illegal config; go on anyway
                        s_nxt.st    = ST_IDENT;
                        s_nxt.ident = 1'b1;
                    end
                end
            end
            ST_PINRST: begin
                if (s_r.cnt == '0) begin
                    s_nxt.pin_n = 1'b1;
                    if (s_r.rst_cfg[SRST_EN_BIT]) begin
                        s_nxt.st   = ST_SRST;
                        s_nxt.srst = 1'b1;
                    end else begin
                        s_nxt.st    = ST_IDENT;
                        s_nxt.ident = 1'b1;
                    end
                end else begin
                    s_nxt.cnt = s_r.cnt - CW'(1);
                end
            end
            ST_SRST: begin
                if (srst_done) begin
                    s_nxt.srst  = 1'b0;
                    s_nxt.st    = ST_IDENT;
                    s_nxt.ident = 1'b1;
                end
            end
            ST_IDENT: begin
                if (cap_valid) begin
                    s_nxt.ident = 1'b0;
                    s_nxt.busy  = 1'b0;
                    s_nxt.st    = ST_IDLE;
                    s_nxt.valid = 1'b1;
                    s_nxt.kind  = sel_if.kind;
                    s_nxt.mode  = sel_if.mode;
                end
            end
            default: begin
                s_nxt.st    = ST_IDLE;
                s_nxt.pin_n = 1'b1;
                s_nxt.srst  = 1'b0;
                s_nxt.ident = 1'b0;
                s_nxt.busy  = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            s_r <= '{st: ST_IDLE, cnt: '0, pwr_up: 1'b1, pin_n: 1'b1,
                     srst: 1'b0, ident: 1'b0, busy: 1'b0,
                     rst_cfg: CFG_RST_RST, udma_cfg: CFG_UDMA_RST,
                     pio_cfg: CFG_PIO_RST, rdata: 8'h00, valid: 1'b0,
                     kind: XK_PIO, mode: PIO_MODE_0};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign drive_hw_reset_pin_n = s_r.pin_n;
    assign srst_req             = s_r.srst;
    assign ident_req            = s_r.ident;
    assign init_busy            = s_r.busy;
    assign mode_valid           = s_r.valid;
    assign xfer_kind            = s_r.kind;
    assign xfer_mode            = s_r.mode;
    assign cfg_rdata            = s_r.rdata;

    pin_skip_a: assert property (@(posedge clock) disable iff (!rst_n)
        (start && !s_r.pwr_up && s_r.rst_cfg[SKIP_PIN_BIT])
        |=> s_r.pin_n [*2])
        else $error("reset pin asserted although skipped");

    pin_state_a: assert property (@(posedge clock) disable iff (!rst_n)
        !s_r.pin_n |-> (s_r.st == ST_PINRST))
        else $error("reset pin low outside pin reset phase");

    pin_release_a: assert property (@(posedge clock) disable iff (!rst_n)
        (s_r.st == ST_PINRST && s_r.cnt == '0) |=> s_r.pin_n)
        else $error("reset pin not released at count end");

    srst_gate_a: assert property (@(posedge clock) disable iff (!rst_n)
        $rose(s_r.srst) |-> $past(s_r.rst_cfg[SRST_EN_BIT]))
        else $error("software reset issued while disabled");

    udma_gate_a: assert property (@(posedge clock) disable iff (!rst_n)
        (cap && sel_if.kind == XK_UDMA) |-> (drv_is_atapi
            ? s_r.udma_cfg[ATAPI_UDMA_BIT] : s_r.udma_cfg[ATA_UDMA_BIT]))
        else $error("udma chosen while disabled for drive type");

    udma_top_a: assert property (@(posedge clock) disable iff (!rst_n)
        (cap && sel_if.kind == XK_UDMA && s_r.udma_cfg[4]
            && drv_udma_sup[4]) |=> (s_r.mode == 3'h4))
        else $error("udma mode 4 available but not chosen");

    mwdma_use_a: assert property (@(posedge clock) disable iff (!rst_n)
        (cap && s_r.pio_cfg[MWDMA_EN_BIT] && drv_mwdma_sup)
        |=> (s_r.kind != XK_PIO))
        else $error("multiword dma available but pio chosen");

    pio_top_a: assert property (@(posedge clock) disable iff (!rst_n)
        (cap && sel_if.kind == XK_PIO && s_r.pio_cfg[PIO4_BIT]
            && drv_pio_sup[PIO4_BIT]) |=> (s_r.mode == PIO_MODE_4))
        else $error("pio mode 4 available but not chosen");

    mode_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
        (s_r.valid && $past(s_r.valid)) |-> $stable(s_r.mode))
        else $error("chosen mode changed between inits");
endmodule : atm_top

/* File: inc/atm_pkg.sv */
package atm_pkg;

    // clock and drive reset pulse timing
    localparam int CLK_PERIOD_PS = 4000;
    localparam int PIN_RST_US    = 25;
    localparam int PIN_RST_CYC   =
        (PIN_RST_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // configuration byte addresses
    localparam logic [7:0] CFG_RST_OFS  = 8'h05;
    localparam logic [7:0] CFG_UDMA_OFS = 8'h06;
    localparam logic [7:0] CFG_PIO_OFS  = 8'h07;

    // reset values of the configuration bytes
    localparam logic [7:0] CFG_RST_RST  = 8'h07;
    localparam logic [7:0] CFG_UDMA_RST = 8'hd4;
    localparam logic [7:0] CFG_PIO_RST  = 8'h07;

    // field positions
    localparam int SKIP_PIN_BIT  = 0;
    localparam int SRST_EN_BIT   = 1;
    localparam int ATA_UDMA_BIT  = 7;
    localparam int ATAPI_UDMA_BIT = 6;
    localparam int MWDMA_EN_BIT  = 2;
    localparam int PIO3_BIT      = 0;
    localparam int PIO4_BIT      = 1;
    localparam int UDMA_LO_BIT   = 2;
    localparam int UDMA_HI_BIT   = 4;
    localparam logic [5:0] UDMA_IMPL_MASK = 6'h1c;

    // fixed mode numbers
    localparam logic [2:0] MWDMA_MODE = 3'h2;
    localparam logic [2:0] PIO_MODE_0 = 3'h0;
    localparam logic [2:0] PIO_MODE_3 = 3'h3;
    localparam logic [2:0] PIO_MODE_4 = 3'h4;

    typedef enum logic [1:0] {
        XK_PIO   = 2'h0,
        XK_MWDMA = 2'h1,
        XK_UDMA  = 2'h2
    } atm_xfer_t;

    typedef enum logic [3:0] {
        ST_IDLE   = 4'h1,
        ST_PINRST = 4'h2,
        ST_SRST   = 4'h4,
        ST_IDENT  = 4'h8
    } atm_state_t;

endpackage : atm_pkg

/* File: inc/atm_sel_if.sv */
`timescale 1ns/1ps
interface atm_sel_if;
    import atm_pkg::*;
    logic [7:0] udma_cfg;
    logic [7:0] pio_cfg;
    logic       is_atapi;
    logic [5:0] drv_udma;
    logic       drv_mwdma;
    logic [1:0] drv_pio;
    atm_xfer_t  kind;
    logic [2:0] mode;

    modport ctl (output udma_cfg, pio_cfg, is_atapi, drv_udma, drv_mwdma,
                 drv_pio, input kind, mode);
    modport sel (input udma_cfg, pio_cfg, is_atapi, drv_udma, drv_mwdma,
                 drv_pio, output kind, mode);
endinterface : atm_sel_if

/* File: logic/atm_mode_sel.sv */
`timescale 1ns/1ps
module atm_mode_sel
    import atm_pkg::*;
(
    atm_sel_if.sel s
);
    logic [5:0] hit;
    logic       udma_en;

    // only modes 2..4 exist; reserved bits are masked even if set
    assign hit = s.udma_cfg[5:0] & s.drv_udma & UDMA_IMPL_MASK;
    assign udma_en = s.is_atapi ? s.udma_cfg[ATAPI_UDMA_BIT]
                                : s.udma_cfg[ATA_UDMA_BIT];

    always_comb begin
        s.kind = XK_PIO;
        s.mode = PIO_MODE_0;
        if (udma_en && (hit != 6'h00)) begin
            s.kind = XK_UDMA;
            // later iterations win, leaving the highest hit
            for (int i = UDMA_LO_BIT; i <= UDMA_HI_BIT; i++) begin
                if (hit[i]) begin
                    s.mode = 3'(i);
                end
            end
        end else if (s.pio_cfg[MWDMA_EN_BIT] && s.drv_mwdma) begin
            s.kind = XK_MWDMA;
            s.mode = MWDMA_MODE;
        end else if (s.pio_cfg[PIO4_BIT] && s.drv_pio[PIO4_BIT]) begin
            s.mode = PIO_MODE_4;
        end else if (s.pio_cfg[PIO3_BIT] && s.drv_pio[PIO3_BIT]) begin
            s.mode = PIO_MODE_3;
        end
    end
endmodule : atm_mode_sel

/* File: sim/atm_drive_model.sv */
`timescale 1ns/1ps
module atm_drive_model (
    // clock and reset
    input  wire logic       clock,
    input  wire logic       rst_n,
    // handshake with the bridge
    input  wire logic       srst_req,
    output logic            srst_done,
    input  wire logic       ident_req,
    output logic            cap_valid,
    // answer delay and capabilities set by the bench
    input  wire logic [3:0] lat,
    input  wire logic [9:0] caps,
    // capability report: atapi, udma[5:0], mwdma, pio[1:0]
    output logic      [9:0] drv_caps
);
    logic [4:0] sc_r;
    logic [4:0] ic_r;

    // counters stop past lat so each request gets exactly one pulse
    always @(posedge clock) begin
        if (!rst_n || !srst_req) sc_r <= 5'h00;
        else if (sc_r <= {1'b0, lat}) sc_r <= sc_r + 5'h01;
        if (!rst_n || !ident_req) ic_r <= 5'h00;
        else if (ic_r <= {1'b0, lat}) ic_r <= ic_r + 5'h01;
    end
    assign srst_done = srst_req && sc_r == {1'b0, lat};
    assign cap_valid = ident_req && ic_r == {1'b0, lat};
    // report lines carry garbage outside the valid cycle
    assign drv_caps  = cap_valid ? caps : ~caps;
endmodule : atm_drive_model

/* File: sim/atm_top_tb_top.sv */
`timescale 1ns/1ps
module atm_top_tb_top
    import atm_pkg::*;
;
    localparam int RC = 4;
    typedef struct packed {
        logic [7:0] u;
        logic [7:0] p;
        logic [9:0] c;
        atm_xfer_t  k;
        logic [2:0] m;
    } atm_row_t;
    atm_row_t   rows [12] = '{
        '{8'hd4, 8'h07, 10'h0ff, XK_UDMA, 3'h4},
        '{8'hd4, 8'h07, 10'h067, XK_UDMA, 3'h2},
        '{8'h98, 8'h07, 10'h2e7, XK_MWDMA, 3'h2},
        '{8'h54, 8'h07, 10'h287, XK_UDMA, 3'h4},
        '{8'h54, 8'h07, 10'h0e7, XK_MWDMA, 3'h2},
        '{8'hd4, 8'h03, 10'h11f, XK_PIO, 3'h4},
        '{8'hd4, 8'h01, 10'h007, XK_PIO, 3'h3},
        '{8'hd4, 8'h00, 10'h007, XK_PIO, 3'h0},
        '{8'hd4, 8'h03, 10'h005, XK_PIO, 3'h3},
        '{8'hd4, 8'h06, 10'h002, XK_PIO, 3'h4},
        '{8'hdc, 8'h04, 10'h01c, XK_MWDMA, 3'h2},
        '{8'h14, 8'h07, 10'h070, XK_PIO, 3'h0}};
    logic [7:0] rbx [4] = '{8'h07, 8'hd4, 8'h07, 8'h00};
    logic [7:0] ro  [3] = '{8'h02, 8'h00, 8'h03};
    logic       clock, rst_n, cfg_wr, init_req, init_busy, pin_n;
    logic       srst_req, srst_done, ident_req, cap_valid, mode_valid;
    logic [7:0] cfg_addr, cfg_wdata, cfg_rdata;
    atm_xfer_t  xfer_kind;
    logic [2:0] xfer_mode;
    logic [3:0] lat;
    logic [9:0] caps, dcaps;
    int         num_errors, cmp_count;

    atm_top #(.RST_CYC(RC)) uut (
        .clock(clock), .rst_n(rst_n), .cfg_wr(cfg_wr),
        .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
        .init_req(init_req), .init_busy(init_busy),
        .drive_hw_reset_pin_n(pin_n), .srst_req(srst_req),
        .srst_done(srst_done), .ident_req(ident_req),
        .cap_valid(cap_valid), .drv_is_atapi(dcaps[9]),
        .drv_udma_sup(dcaps[8:3]), .drv_mwdma_sup(dcaps[2]),
        .drv_pio_sup(dcaps[1:0]), .mode_valid(mode_valid),
        .xfer_kind(xfer_kind), .xfer_mode(xfer_mode));
    atm_drive_model drv (
        .clock(clock), .rst_n(rst_n), .srst_req(srst_req),
        .srst_done(srst_done), .ident_req(ident_req),
        .cap_valid(cap_valid), .lat(lat), .caps(caps), .drv_caps(dcaps));

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    task automatic tick;
        @(posedge clock);
        #1;
    endtask : tick

    task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                       input string what);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic cmp_mode(input atm_xfer_t k, input logic [2:0] m);
        chk({6'h00, xfer_kind}, {6'h00, k}, "kind");
        chk({5'h00, xfer_mode}, {5'h00, m}, "mode");
    endtask : cmp_mode

    task automatic stop_test;
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : stop_test

    task automatic cfg_write(input logic [7:0] a, input logic [7:0] d);
        cfg_wr = 1'b1;
        cfg_addr = a;
        cfg_wdata = d;
        tick;
        cfg_wr = 1'b0;
        tick;
    endtask : cfg_write

    // counts pin reset cycles and watches for a soft reset until done
    task automatic wait_done(input int exp_pin, input logic exp_srst);
        int   pins;
        logic seen;
        logic idn;
        pins = 0;
        seen = 1'b0;
        idn  = 1'b0;
        for (int n = 0; n < 400; n++) begin
            if (mode_valid === 1'b1 && init_busy === 1'b0) break;
            if (pin_n === 1'b0) pins++;
            if (srst_req === 1'b1) seen = 1'b1;
            if (ident_req === 1'b1) idn = 1'b1;
            tick;
        end
        if (mode_valid !== 1'b1) begin
            num_errors++;
            $display("Error at %0t: init never finished", $time);
            stop_test;
        end else begin
            chk(8'(pins), 8'(exp_pin), "pin reset cycles");
            chk({7'h00, seen}, {7'h00, exp_srst}, "soft reset");
            chk({7'h00, idn}, 8'h01, "identify");
        end
    endtask : wait_done

    task automatic run_init(input int exp_pin, input logic exp_srst);
        init_req = 1'b1;
        tick;
        init_req = 1'b0;
        chk({7'h00, init_busy}, 8'h01, "busy");
        chk({7'h00, mode_valid}, 8'h00, "valid cleared");
        wait_done(exp_pin, exp_srst);
    endtask : run_init

    initial begin
        rst_n = 1'b0;
        cfg_wr = 1'b0;
        cfg_addr = 8'h00;
        cfg_wdata = 8'h00;
        init_req = 1'b0;
        lat = 4'h2;
        caps = 10'h007;
        num_errors = 0;
        cmp_count = 0;
        repeat (20) tick;
        rst_n = 1'b1;
        wait_done(RC, 1'b1);
        cmp_mode(XK_MWDMA, 3'h2);
        $display("test power_up done");
        cfg_write(8'h08, 8'h5a);
        for (int a = 0; a < 4; a++) begin
            cfg_addr = 8'(a + 5);
            tick;
            chk(cfg_rdata, rbx[a], "readback");
        end
        $display("test readback done");
        for (int i = 0; i < 12; i++) begin
            cfg_write(CFG_UDMA_OFS, rows[i].u);
            cfg_write(CFG_PIO_OFS, rows[i].p);
            caps = rows[i].c;
            lat = i[0] ? 4'h5 : 4'h1;
            run_init(0, 1'b1);
            cmp_mode(rows[i].k, rows[i].m);
        end
        $display("test mode_table done");
        // a new config without a new init must not move the mode
        cfg_write(CFG_PIO_OFS, 8'h07);
        caps = 10'h3ff;
        tick;
        cmp_mode(XK_PIO, 3'h0);
        $display("test mode_hold done");
        for (int i = 0; i < 3; i++) begin
            cfg_write(CFG_RST_OFS, ro[i]);
            run_init(i == 2 ? 0 : RC, ro[i][1]);
        end
        $display("test reset_options done");
        // chip reset with skip set must still pulse the pin afterwards
        rst_n = 1'b0;
        repeat (3) tick;
        chk({6'h00, pin_n, mode_valid}, 8'h02, "reset outputs");
        rst_n = 1'b1;
        wait_done(RC, 1'b1);
        cmp_mode(XK_UDMA, 3'h4);
        $display("test mid_reset done");
        stop_test;
    end
endmodule : atm_top_tb_top
